// ==== shared/can_ctrl_pkg.sv ====
// constants, field positions and mode codes of the can control/status block
// assumes a single 32-bit register slave clocked by ref_clk
package can_ctrl_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int HADDR_W = 32;
  localparam int OFF_W = 8;
  localparam logic [OFF_W-1:0] OFF_CONTROL = 8'h00;
  localparam logic [OFF_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [OFF_W-1:0] OFF_TX_STATUS = 8'h08;
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic [31:0] CONTROL_RESET = 32'h00010002;
  localparam logic [31:0] STATUS_RESET = 32'h00000c02;
  localparam logic [31:0] TX_STATUS_RESET = 32'h1c000000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTL_DFZ = 16;
  localparam int CTL_SOFT_RESET_REQUEST = 15;
  localparam int CTL_TTC = 7;
  localparam int CTL_AUTO_BUSOFF_RECOVERY = 6;
  localparam int CTL_AWU = 5;
  localparam int CTL_ARD = 4;
  localparam int CTL_RX_FIFO_OVERWRITE_DISABLE = 3;
  localparam int CTL_TFO = 2;
  localparam int CTL_SLEEP = 1;
  localparam int CTL_INIT = 0;
  localparam int ST_RXL = 11;
  localparam int ST_RX_LAST_SAMPLE = 10;
  localparam int ST_RS = 9;
  localparam int ST_TS = 8;
  localparam int ST_SLEEP_ENTRY_IRQ_FLAG = 4;
  localparam int ST_WAKEUP_IRQ_FLAG = 3;
  localparam int ST_ERROR_IRQ_FLAG = 2;
  localparam int ST_SLEEP_STATE = 1;
  localparam int ST_IWS = 0;
  localparam int TX_LAST0 = 29;
  localparam int TX_EMPTY0 = 26;

  // ----------------------------------------------------------------
  // counts and codes
  // ----------------------------------------------------------------
  localparam int NUM_MBOX = 3;
  localparam logic [3:0] RECESSIVE_RUN = 4'hb;
  localparam logic [7:0] RECOVERY_RUNS = 8'h80;
  localparam logic [2:0] ERR_CODE_MIN = 3'h1;
  localparam logic [2:0] ERR_CODE_MAX = 3'h6;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_INIT = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_LEAVE_INIT = 3'b011,
    MODE_LEAVE_SLEEP = 3'b100
  } mode_t;

endpackage

// ==== rtl/can_ctrl_regs.sv ====
// control and status registers and mode sequencing of a can controller
// assumes an ahb-lite master on ref_clk, the protocol core on the same
// clock, and rx pin / debug hold arriving from outside the clock domain
`timescale 1ns/1ps

module can_ctrl_regs (
  input wire logic ref_clk,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [can_ctrl_pkg::HADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // asynchronous inputs
  input wire logic rx_pin,
  input wire logic debug_hold_request,
  // protocol core, same clock
  input wire logic bit_tick,
  input wire logic rx_busy,
  input wire logic tx_busy,
  input wire logic busoff_status,
  input wire logic passive_status,
  input wire logic warning_status,
  input wire logic [2:0] last_error_code,
  input wire logic busoff_irq_enable,
  input wire logic passive_irq_enable,
  input wire logic warning_irq_enable,
  input wire logic error_code_irq_enable,
  input wire logic rx_frame_valid,
  input wire logic rx_fifo_full,
  input wire logic tx_attempt_ok,
  input wire logic tx_attempt_fail,
  input wire logic [2:0] mbox_request,
  input wire logic [2:0] mbox_pending,
  input wire logic [1:0] lowest_prio_mbox,
  // controls to the protocol core
  output logic core_freeze,
  output logic core_reset,
  output logic init_mode,
  output logic sleep_mode,
  output logic busoff_recovered,
  output logic auto_retransmit_disable,
  output logic tx_order_select,
  output logic time_triggered_enable,
  output logic rx_store,
  output logic rx_overwrite,
  output logic tx_retry,
  output logic tx_done
);
  import can_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    mode_t mode;
    logic in_init;
    logic in_sleep;
    logic debug_freeze;
    logic time_triggered_enable;
    logic auto_busoff_recovery;
    logic auto_wakeup;
    logic auto_retransmit_disable;
    logic rx_fifo_overwrite_disable;
    logic tx_order_select;
    logic sleep_request;
    logic init_request;
    logic soft_reset;
    logic sleep_entry_irq_flag;
    logic wakeup_irq_flag;
    logic error_irq_flag;
    logic [2:0] rx_sync;
    logic [2:0] hold_sync;
    logic rx_pin_level;
    logic hold_level;
    logic rx_last_sample;
    logic receiving_flag;
    logic transmitting_flag;
    logic [3:0] rec_cnt;
    logic rec11;
    logic [7:0] runs;
    logic sw_armed;
    logic recovered;
    logic [2:0] pending;
    logic [1:0] last_req;
    logic [2:0] last_order;
    logic freeze;
    logic rx_store;
    logic rx_overwrite;
    logic tx_retry;
    logic tx_done;
    logic ph_valid;
    logic ph_write;
    logic [OFF_W-1:0] ph_addr;
    logic [31:0] rdata;
    logic readyout;
  } state_t;

  state_t st;
  state_t next_st;
  logic take;
  logic activity;
  logic frame_busy;
  logic err_cause;
  logic wr_ctl;
  logic wr_stat;

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  // register read, reserved bits zero
  // reserved bits zero
  function automatic logic [31:0] reg_read(state_t s, logic [OFF_W-1:0] a);
    logic [31:0] v;
    v = 32'h00000000;
    unique case (a)
      OFF_CONTROL: begin
        v[CTL_DFZ] = s.debug_freeze;
        v[CTL_TTC] = s.time_triggered_enable;
        v[CTL_AUTO_BUSOFF_RECOVERY] = s.auto_busoff_recovery;
        v[CTL_AWU] = s.auto_wakeup;
        v[CTL_ARD] = s.auto_retransmit_disable;
        v[CTL_RX_FIFO_OVERWRITE_DISABLE] = s.rx_fifo_overwrite_disable;
        v[CTL_TFO] = s.tx_order_select;
        v[CTL_SLEEP] = s.sleep_request;
        v[CTL_INIT] = s.init_request;
      end
      OFF_STATUS: begin
        v[ST_RXL] = s.rx_pin_level;
        v[ST_RX_LAST_SAMPLE] = s.rx_last_sample;
        v[ST_RS] = s.receiving_flag;
        v[ST_TS] = s.transmitting_flag;
        v[ST_SLEEP_ENTRY_IRQ_FLAG] = s.sleep_entry_irq_flag;
        v[ST_WAKEUP_IRQ_FLAG] = s.wakeup_irq_flag;
        v[ST_ERROR_IRQ_FLAG] = s.error_irq_flag;
        v[ST_SLEEP_STATE] = s.in_sleep | (s.mode == MODE_LEAVE_SLEEP);
        v[ST_IWS] = s.in_init | (s.mode == MODE_LEAVE_INIT);
      end
      OFF_TX_STATUS: begin
        v[TX_LAST0 +: NUM_MBOX] = s.last_order;
        v[TX_EMPTY0 +: NUM_MBOX] = ~s.pending;
      end
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // one combinational pass over the whole block
  always_comb begin
    next_st = st;
    next_st.soft_reset = 1'b0;
    next_st.rec11 = 1'b0;
    next_st.recovered = 1'b0;

    // bus address phase; zero wait, always okay
    take = hsel & htrans[HTRANS_ACTIVE_BIT] & hready;
    next_st.ph_valid = take;
    next_st.ph_write = hwrite;
    next_st.ph_addr = haddr[OFF_W-1:0];
    next_st.readyout = 1'b1;
    next_st.rdata = 32'h00000000;
    if (take && !hwrite) begin
      next_st.rdata = reg_read(st, haddr[OFF_W-1:0]);
    end
    wr_ctl = st.ph_valid & st.ph_write & (st.ph_addr == OFF_CONTROL);
    wr_stat = st.ph_valid & st.ph_write & (st.ph_addr == OFF_STATUS);

    // three-stage pin synchronisers, change taken when last two agree
    next_st.rx_sync = {st.rx_sync[1:0], rx_pin};
    next_st.hold_sync = {st.hold_sync[1:0], debug_hold_request};
    activity = 1'b0;
    if (st.rx_sync[1] == st.rx_sync[2]) begin
      next_st.rx_pin_level = st.rx_sync[2];
      activity = st.rx_pin_level & !st.rx_sync[2];
    end
    if (st.hold_sync[1] == st.hold_sync[2]) begin
      next_st.hold_level = st.hold_sync[2];
    end

    next_st.freeze = st.debug_freeze & st.hold_level;

    next_st.receiving_flag = rx_busy;
    next_st.transmitting_flag = tx_busy;
    frame_busy = rx_busy | tx_busy;

    // sample pin at bit sample point
    if (bit_tick) begin
      next_st.rx_last_sample = st.rx_pin_level;
    end

    // runs of eleven recessive bits
    if (bit_tick) begin
      if (!st.rx_pin_level) begin
        next_st.rec_cnt = 4'h0;
      end else if (st.rec_cnt == RECESSIVE_RUN - 4'h1) begin
        next_st.rec_cnt = 4'h0;
        next_st.rec11 = 1'b1;
      end else begin
        next_st.rec_cnt = st.rec_cnt + 4'h1;
      end
    end

    // mode sequencing
    unique case (st.mode)
      MODE_NORMAL: begin
        if (st.init_request && !frame_busy) begin
          next_st.mode = MODE_INIT;
        end else if (st.sleep_request && !frame_busy) begin
          next_st.mode = MODE_SLEEP;
        end
      end
      MODE_INIT: begin
        if (!st.init_request) begin
          next_st.mode = st.sleep_request ? MODE_SLEEP : MODE_LEAVE_INIT;
        end
      end
      MODE_LEAVE_INIT: begin
        if (st.init_request) begin
          next_st.mode = MODE_INIT;
        end else if (st.rec11) begin
          next_st.mode = MODE_NORMAL;
        end
      end
      MODE_SLEEP: begin
        if (st.init_request) begin
          next_st.mode = MODE_INIT;
        end else if (!st.sleep_request) begin
          next_st.mode = MODE_LEAVE_SLEEP;
        end else if (st.auto_wakeup && activity) begin
          next_st.mode = MODE_LEAVE_SLEEP;
        end
      end
      MODE_LEAVE_SLEEP: begin
        // sleep flag held until recessive run
        if (st.sleep_request) begin
          next_st.mode = MODE_SLEEP;
        end else if (st.rec11) begin
          next_st.mode = MODE_NORMAL;
        end
      end
      default: next_st.mode = MODE_SLEEP;
    endcase

    // fresh recessive run on every leave
    if ((next_st.mode == MODE_LEAVE_INIT && st.mode != MODE_LEAVE_INIT) ||
        (next_st.mode == MODE_LEAVE_SLEEP &&
         st.mode != MODE_LEAVE_SLEEP)) begin
      next_st.rec_cnt = 4'h0;
      next_st.rec11 = 1'b0;
    end

    // arm recovery, automatic or via init exit
    if (!busoff_status) begin
      next_st.sw_armed = 1'b0;
    end else if (st.mode == MODE_LEAVE_INIT) begin
      next_st.sw_armed = 1'b1;
    end
    if (!busoff_status || !(st.auto_busoff_recovery || st.sw_armed)) begin
      next_st.runs = 8'h00;
    end else if (st.rec11) begin
      if (st.runs == RECOVERY_RUNS - 8'h01) begin
        next_st.runs = 8'h00;
        next_st.recovered = 1'b1;
      end else begin
        next_st.runs = st.runs + 8'h01;
      end
    end

    // overwrite or discard on full fifo
    next_st.rx_store = rx_frame_valid &
                       (!rx_fifo_full | !st.rx_fifo_overwrite_disable);
    next_st.rx_overwrite = rx_frame_valid & rx_fifo_full &
                           !st.rx_fifo_overwrite_disable;
    next_st.tx_retry = tx_attempt_fail & !st.auto_retransmit_disable;
    next_st.tx_done = tx_attempt_ok |
                      (tx_attempt_fail & st.auto_retransmit_disable);

    for (int i = 0; i < NUM_MBOX; i++) begin
      if (mbox_request[i]) begin
        next_st.last_req = 2'(i);
      end
    end
    next_st.pending = mbox_pending;
    for (int i = 0; i < NUM_MBOX; i++) begin
      next_st.last_order[i] =
        ((st.pending[0] & st.pending[1]) | (st.pending[0] & st.pending[2]) |
         (st.pending[1] & st.pending[2])) & st.pending[i] &
        ((st.tx_order_select ? st.last_req : lowest_prio_mbox) == 2'(i));
    end

    // control writes
    if (wr_ctl) begin
      next_st.debug_freeze = hwdata[CTL_DFZ];
      next_st.time_triggered_enable = hwdata[CTL_TTC];
      next_st.auto_busoff_recovery = hwdata[CTL_AUTO_BUSOFF_RECOVERY];
      next_st.auto_wakeup = hwdata[CTL_AWU];
      next_st.auto_retransmit_disable = hwdata[CTL_ARD];
      next_st.rx_fifo_overwrite_disable = hwdata[CTL_RX_FIFO_OVERWRITE_DISABLE];
      next_st.tx_order_select = hwdata[CTL_TFO];
      next_st.sleep_request = hwdata[CTL_SLEEP];
      next_st.init_request = hwdata[CTL_INIT];
    end
    if (wr_stat) begin
      if (hwdata[ST_SLEEP_ENTRY_IRQ_FLAG]) next_st.sleep_entry_irq_flag = 1'b0;
      if (hwdata[ST_WAKEUP_IRQ_FLAG]) next_st.wakeup_irq_flag = 1'b0;
      if (hwdata[ST_ERROR_IRQ_FLAG]) next_st.error_irq_flag = 1'b0;
    end

    // hardware sets after status clears so a status write never loses an event; a soft reset still drops one
    // hardware drops sleep request
    if (st.mode == MODE_SLEEP && st.auto_wakeup && activity &&
        !st.init_request) begin
      next_st.sleep_request = 1'b0;
    end
    if (st.mode == MODE_SLEEP && activity) begin
      next_st.wakeup_irq_flag = 1'b1;
    end
    // set on entry, dropped outside sleep
    if (next_st.mode == MODE_SLEEP && st.mode != MODE_SLEEP) begin
      next_st.sleep_entry_irq_flag = 1'b1;
    end else if (next_st.mode != MODE_SLEEP &&
                 next_st.mode != MODE_LEAVE_SLEEP) begin
      next_st.sleep_entry_irq_flag = 1'b0;
    end
    err_cause = (busoff_status & busoff_irq_enable) |
                (passive_status & passive_irq_enable) |
                (warning_status & warning_irq_enable) |
                (error_code_irq_enable &&
                 last_error_code >= ERR_CODE_MIN &&
                 last_error_code <= ERR_CODE_MAX);
    if (err_cause) begin
      next_st.error_irq_flag = 1'b1;
    end

    if (wr_ctl && hwdata[CTL_SOFT_RESET_REQUEST]) begin
      next_st.soft_reset = 1'b1;
      next_st.mode = MODE_SLEEP;
      next_st.debug_freeze = CONTROL_RESET[CTL_DFZ];
      next_st.time_triggered_enable = CONTROL_RESET[CTL_TTC];
      next_st.auto_busoff_recovery = CONTROL_RESET[CTL_AUTO_BUSOFF_RECOVERY];
      next_st.auto_wakeup = CONTROL_RESET[CTL_AWU];
      next_st.auto_retransmit_disable = CONTROL_RESET[CTL_ARD];
      next_st.rx_fifo_overwrite_disable = CONTROL_RESET[CTL_RX_FIFO_OVERWRITE_DISABLE];
      next_st.tx_order_select = CONTROL_RESET[CTL_TFO];
      next_st.sleep_request = CONTROL_RESET[CTL_SLEEP];
      next_st.init_request = CONTROL_RESET[CTL_INIT];
      next_st.sleep_entry_irq_flag = STATUS_RESET[ST_SLEEP_ENTRY_IRQ_FLAG];
      next_st.wakeup_irq_flag = STATUS_RESET[ST_WAKEUP_IRQ_FLAG];
      next_st.error_irq_flag = STATUS_RESET[ST_ERROR_IRQ_FLAG];
      next_st.runs = 8'h00;
      next_st.sw_armed = 1'b0;
    end

    next_st.in_init = (next_st.mode == MODE_INIT);
    next_st.in_sleep = (next_st.mode == MODE_SLEEP);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // constant reset values only
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.mode <= MODE_SLEEP;
      st.in_sleep <= 1'b1;
      st.debug_freeze <= CONTROL_RESET[CTL_DFZ];
      st.sleep_request <= CONTROL_RESET[CTL_SLEEP];
      st.rx_sync <= 3'h7;
      st.hold_sync <= 3'h0;
      st.rx_pin_level <= STATUS_RESET[ST_RXL];
      st.rx_last_sample <= STATUS_RESET[ST_RX_LAST_SAMPLE];
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register, hresp tied low
  assign hrdata = st.rdata;
  assign hreadyout = st.readyout;
  assign hresp = 1'b0;
  assign core_freeze = st.freeze;
  assign core_reset = st.soft_reset;
  assign init_mode = st.in_init;
  assign sleep_mode = st.in_sleep;
  assign busoff_recovered = st.recovered;
  assign auto_retransmit_disable = st.auto_retransmit_disable;
  assign tx_order_select = st.tx_order_select;
  assign time_triggered_enable = st.time_triggered_enable;
  assign rx_store = st.rx_store;
  assign rx_overwrite = st.rx_overwrite;
  assign tx_retry = st.tx_retry;
  assign tx_done = st.tx_done;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence soft_reset_request_write;
    st.ph_valid && st.ph_write && st.ph_addr == OFF_CONTROL &&
    hwdata[CTL_SOFT_RESET_REQUEST];
  endsequence
  sequence sleep_with_wake;
    st.mode == MODE_SLEEP && st.auto_wakeup && activity &&
    !st.init_request;
  endsequence

  a_freeze_gate: assert property (
    core_freeze |-> $past(st.hold_level) && $past(st.debug_freeze))
    else $error("freeze without hold and freeze bit");
  a_soft_reset_request_sleep: assert property (
    soft_reset_request_write |=> sleep_mode && core_reset && st.sleep_request
                    ##1 !core_reset)
    else $error("soft reset did not reach sleep");
  a_busoff_runs: assert property (
    busoff_recovered |-> $past(st.runs) == RECOVERY_RUNS - 8'h01)
    else $error("recovery before 128 runs");
  a_wake_clear: assert property (
    sleep_with_wake |=> !st.sleep_request && !sleep_mode)
    else $error("auto wakeup did not clear request");
  a_sleep_wait: assert property (
    $rose(sleep_mode) && $past(st.mode) == MODE_NORMAL |->
    $past(!rx_busy && !tx_busy))
    else $error("sleep entered during frame");
  a_init_leave: assert property (
    st.mode == MODE_LEAVE_INIT ##1 st.mode == MODE_NORMAL |->
    $past(st.rec11))
    else $error("init left without recessive run");
  a_sleep_entry_irq_flag_entry: assert property (
    $rose(sleep_mode) && !core_reset |-> st.sleep_entry_irq_flag)
    else $error("sleep entry flag not set");
  a_wakeup_irq_flag_sticky: assert property (
    st.wakeup_irq_flag && !wr_stat |=> st.wakeup_irq_flag)
    else $error("wakeup flag lost without write");
  a_err_set: assert property (
    err_cause |=> st.error_irq_flag)
    else $error("error flag not set");
  a_overwrite: assert property (
    rx_frame_valid && rx_fifo_full |=>
    rx_store == !$past(st.rx_fifo_overwrite_disable))
    else $error("full fifo handling wrong");
  a_one_attempt: assert property (
    tx_attempt_fail && st.auto_retransmit_disable |=> tx_done && !tx_retry)
    else $error("retry with retransmit disabled");

endmodule

// ==== testbench/can_bus_node.sv ====
// far-side can node: bit sample ticks and the rx line level
// assumes one can bit every four ref_clk cycles, rx idles recessive
`timescale 1ns/1ps

module can_bus_node (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic dominant,
  output logic rx_pin,
  output logic bit_tick
);
  logic [1:0] phase;

  // ----------------------------------------------------------------
  // bit timing and bus level
  // ----------------------------------------------------------------
  // tick at the sample point, line high unless a node pulls dominant
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase <= 2'h0;
      bit_tick <= 1'b0;
      rx_pin <= 1'b1;
    end else begin
      phase <= phase + 2'h1;
      bit_tick <= (phase == 2'h3);
      rx_pin <= !dominant; // recessive is high
    end
  end
endmodule

// ==== testbench/can_control_status_regs_test.sv ====
// self-checking bench for the can control/status register block
// assumes the ahb-lite slave is the only one, hready = hreadyout
`timescale 1ns/1ps

module can_control_status_regs_test;
  import can_ctrl_pkg::*;
  logic ref_clk, rstn, hsel, hwrite, hreadyout, hresp, rx_pin, bit_tick;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, lowest_prio_mbox;
  logic [2:0] hsize, last_error_code, mbox_request, mbox_pending;
  logic dominant, debug_hold_request, rx_busy, tx_busy, busoff_status;
  logic passive_status, warning_status, busoff_irq_enable;
  logic passive_irq_enable, warning_irq_enable, error_code_irq_enable;
  logic rx_frame_valid, rx_fifo_full, tx_attempt_ok, tx_attempt_fail;
  logic core_freeze, init_mode, sleep_mode, auto_retransmit_disable;
  logic tx_order_select, time_triggered_enable, rx_store, rx_overwrite;
  logic tx_retry, tx_done, core_reset, busoff_recovered;
  int fails, num_checks, n;

  can_ctrl_regs dut_u (
    .ref_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_pin,
    .debug_hold_request, .bit_tick, .rx_busy, .tx_busy, .busoff_status,
    .passive_status, .warning_status, .last_error_code, .busoff_irq_enable,
    .passive_irq_enable, .warning_irq_enable, .error_code_irq_enable,
    .rx_frame_valid, .rx_fifo_full, .tx_attempt_ok, .tx_attempt_fail,
    .mbox_request, .mbox_pending, .lowest_prio_mbox, .core_freeze,
    .core_reset, .init_mode, .sleep_mode, .busoff_recovered,
    .auto_retransmit_disable, .tx_order_select, .time_triggered_enable,
    .rx_store, .rx_overwrite, .tx_retry, .tx_done
  );

  can_bus_node node_u (.ref_clk, .rstn, .dominant, .rx_pin, .bit_tick);

  // ----------------------------------------------------------------
  // clock, compare and bus tasks
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  // hreadyout is registered, so it is steady at the falling edge
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge ref_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        fails++;
        print_verdict();
      end
      @(negedge ref_clk);
    end
  endtask

  // one single word transfer, then one idle cycle
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    @(posedge ref_clk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q & m, e);
  endtask

  task automatic poll(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    int n;
    n = 0;
    bus(1'b0, a, 32'h0);
    while ((q & m) !== e && n < 200) begin
      bus(1'b0, a, 32'h0);
      n++;
    end
    check(q & m, e);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    fails = 0;
    num_checks = 0;
    rstn <= 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata, dominant, rx_busy} <= '0;
    {debug_hold_request, tx_busy, rx_frame_valid, rx_fifo_full} <= '0;
    {tx_attempt_ok, tx_attempt_fail, mbox_request, mbox_pending} <= '0;
    {last_error_code, error_code_irq_enable, lowest_prio_mbox} <= '0;
    {busoff_status, passive_status, warning_status} <= 3'h0;
    {busoff_irq_enable, passive_irq_enable, warning_irq_enable} <= 3'h0;
    hsize <= 3'h2;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(8'h00, 32'hffffffff, CONTROL_RESET);
    rd(8'h04, 32'hffffffff, STATUS_RESET);
    rd(8'h08, 32'hffffffff, TX_STATUS_RESET);
    rd(8'h0c, 32'hffffffff, 32'h0);
    bus(1'b1, 8'h00, 32'hfffe00fc);
    rd(8'h00, 32'hffffffff, 32'h000000fc);
    check(tx_order_select, 1'b1);
    check(time_triggered_enable, 1'b1);
    poll(8'h04, 32'h2, 32'h0);
    check(sleep_mode, 1'b0);
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, 8'h00, k ? 32'h000000e0 : 32'h000000fc);
      @(posedge ref_clk);
      rx_frame_valid <= 1'b1;
      rx_fifo_full <= 1'b1;
      tx_attempt_fail <= 1'b1;
      @(posedge ref_clk);
      rx_frame_valid <= 1'b0;
      tx_attempt_fail <= 1'b0;
      @(negedge ref_clk);
      check(rx_store, k);
      check(rx_overwrite, k);
      check(tx_retry, k);
      check(tx_done, !k);
    end
    check(tx_order_select, 1'b0);
    @(posedge ref_clk);
    mbox_pending <= 3'b011;
    mbox_request <= 3'b010;
    lowest_prio_mbox <= 2'h1;
    @(posedge ref_clk);
    mbox_request <= 3'b000;
    poll(8'h08, 32'hffffffff, 32'h50000000);
    for (int i = 0; i < 11; i++) begin
      @(posedge ref_clk);
      last_error_code <= (i < 8) ? i[2:0] : 3'h0;
      error_code_irq_enable <= (i < 8);
      {busoff_status, passive_status, warning_status} <=
        (i < 8) ? 3'h0 : 3'h4 >> (i - 8);
      {busoff_irq_enable, passive_irq_enable, warning_irq_enable} <= 3'h7;
      @(posedge ref_clk);
      last_error_code <= 3'h0;
      {busoff_status, passive_status, warning_status} <= 3'h0;
      bus(1'b1, 8'h04, 32'h0);
      rd(8'h04, 32'h4, (i > 0 && i != 7) ? 32'h4 : 32'h0);
      bus(1'b1, 8'h04, 32'h4);
      rd(8'h04, 32'h4, 32'h0);
    end
    @(posedge ref_clk);
    rx_busy <= 1'b1;
    tx_busy <= 1'b1;
    dominant <= 1'b1;
    bus(1'b1, 8'h00, 32'h000000e2);
    repeat (12) @(posedge ref_clk);
    rd(8'h04, 32'hfff, 32'h00000300);
    @(posedge ref_clk);
    {rx_busy, tx_busy, dominant} <= 3'h0;
    poll(8'h04, 32'h12, 32'h12);
    @(posedge ref_clk);
    dominant <= 1'b1;
    poll(8'h00, 32'h2, 32'h0);
    @(posedge ref_clk);
    dominant <= 1'b0;
    poll(8'h04, 32'h1a, 32'h08);
    bus(1'b1, 8'h04, 32'h8);
    rd(8'h04, 32'h8, 32'h0);
    bus(1'b1, 8'h00, 32'h000000e1);
    poll(8'h04, 32'h1, 32'h1);
    check(init_mode, 1'b1);
    bus(1'b1, 8'h00, 32'h000000e0);
    rd(8'h04, 32'h1, 32'h1);
    poll(8'h04, 32'h1, 32'h0);
    debug_hold_request <= 1'b1;
    bus(1'b1, 8'h00, 32'h000100e0);
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    check(core_freeze, 1'b1);
    debug_hold_request <= 1'b0;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    check(core_freeze, 1'b0);
    bus(1'b1, 8'h00, 32'h00008000);
    @(negedge ref_clk);
    check(core_reset, 1'b1);
    rd(8'h00, 32'hffffffff, 32'h00010002);
    rd(8'h04, 32'h2, 32'h2);
    // automatic bus-off recovery needs 128 recessive runs
    bus(1'b1, 8'h00, 32'h00000040);
    busoff_status <= 1'b1;
    n = 0;
    while (busoff_recovered !== 1'b1 && n < 8000) begin
      @(negedge ref_clk);
      n++;
    end
    check(busoff_recovered, 1'b1);
    check(n > 5000, 1'b1);
    busoff_status <= 1'b0;
    print_verdict();
  end
endmodule
